// ### src/ivr_pkg.sv
// Constants for the interrupt vector relocation block
package ivr_pkg;
   // Register map (byte addresses on the AHB-Lite slave)
   localparam logic [7:0] GIC_OFFSET = 8'h00;
   localparam logic [7:0] FUSE_OFFSET = 8'h04;
   localparam logic [7:0] STAT_OFFSET = 8'h08;
   // Field positions in general_interrupt_control
   localparam int UNLOCK_BIT = 0;
   localparam int SELECT_BIT = 1;
   // Field positions in the fuse/lock register
   localparam int BOOT_RESET_BIT = 0;
   localparam int BOOT_SIZE_LO = 1;
   localparam int APP_LOCK_BIT = 3;
   localparam int BOOT_LOCK_BIT = 4;
   // Fuse reset value: boot reset unprogrammed (1), 2K boot area (00), locks off (1)
   localparam logic [7:0] FUSE_RESET = 8'h19;
   localparam logic [7:0] GIC_RESET = 8'h00;
   // Unlock window in CPU cycles
   localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
   // Program counter width in bits (word addresses)
   localparam int PC_W = 12;
   // Boot area start words per boot-size code (00 = 2K bytes = 1K words)
   localparam logic [11:0] BOOT_START_0 = 12'hC00;
   localparam logic [11:0] BOOT_START_1 = 12'hE00;
   localparam logic [11:0] BOOT_START_2 = 12'hF00;
   localparam logic [11:0] BOOT_START_3 = 12'hF80;
   // AHB constants
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] HTRANS_SEQ = 2'h3;
   localparam logic HRESP_OKAY = 1'b0;
endpackage

// ### src/ivr_vector_calc.sv
// Vector address computation from fuses and select bit
`timescale 1ns/100ps
module ivr_vector_calc (
   input wire logic [1:0] i_boot_size,
   input wire logic i_boot_reset_n,
   input wire logic i_select,
   input wire logic [4:0] i_vec_num,
   output logic [11:0] o_boot_start,
   output logic [11:0] o_reset_addr,
   output logic [11:0] o_vec_addr
);
   // Boot start from size code; larger code means smaller boot area
   always_comb begin
      case (i_boot_size)
         2'h0: o_boot_start = ivr_pkg::BOOT_START_0;
         2'h1: o_boot_start = ivr_pkg::BOOT_START_1;
         2'h2: o_boot_start = ivr_pkg::BOOT_START_2;
         default: o_boot_start = ivr_pkg::BOOT_START_3;
      endcase
   end

   // Reset vector follows the boot reset and boot size fuses, not the select bit
   assign o_reset_addr = i_boot_reset_n ? 12'h000 : o_boot_start;

   // One word per vector, base offset by boot start when relocated
   assign o_vec_addr = (i_select ? o_boot_start : 12'h000) + {7'h00, i_vec_num};
endmodule

// ### src/ivr_top.sv
// Interrupt vector relocation controller with AHB-Lite register access
// Operation
// - Select bit picks application or boot table
// - Boot start derived from boot size fuses
// - Interrupts blocked from unlock through next instruction
// - Unwritten unlock blocks interrupts four cycles
// - Global interrupt enable bit left untouched
// - Unlock clears after four cycles or select
// - Boot vectors plus app lock block app
// - App vectors plus boot lock block boot
// - Fuse off, select on: reset 000, vectors C01
// - Fuse on, select off: reset C00, vectors 001
// - Fuse on, select on: all C00 through C12
// - Programmed boot fuse moves reset address
// - Relocated vector equals base plus boot start
`timescale 1ns/100ps
module ivr_top #(
   parameter int NUM_SRC = 18
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   // AHB-Lite slave
   input wire logic i_hsel,
   input wire logic [7:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   // Core side
   input wire logic [11:0] i_core_pc,
   input wire logic i_instr_done,
   input wire logic [NUM_SRC-1:0] i_irq_src,
   input wire logic i_global_ie,
   output logic o_irq_req,
   output logic [11:0] o_irq_vector,
   output logic [11:0] o_reset_vector,
   output logic o_irq_blocked
);
   ////////////////////////////////////////////////////////////////////////
   // Unlock sequence states
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_ARMED = 3'b010,
      ST_TAIL = 3'b100
   } seq_type;

   seq_type st_q, st_d;
   logic [2:0] cnt_q, cnt_d;
   logic sel_q, sel_d;
   logic [7:0] fuse_q, fuse_d;
   logic wr_pend_q, wr_pend_d;
   logic [7:0] addr_q, addr_d;
   logic [31:0] rdata_q, rdata_d;
   logic irq_q, irq_d;
   logic [11:0] vec_q, vec_d;
   logic [11:0] rst_q, rst_d;
   logic blk_q, blk_d;
   logic wr_gic, wr_fuse, seq_block, lock_block, in_boot;
   logic [4:0] vec_num;
   logic [11:0] boot_start, reset_addr, vec_addr;

   ////////////////////////////////////////////////////////////////////////
   // Bus address phase capture; zero wait states so hreadyout stays high
   always_comb begin
      wr_pend_d = 1'b0;
      addr_d = addr_q;
      if (i_hsel && i_hready && (i_htrans == ivr_pkg::HTRANS_NONSEQ ||
            i_htrans == ivr_pkg::HTRANS_SEQ)) begin
         wr_pend_d = i_hwrite;
         addr_d = i_haddr;
      end
   end

   assign wr_gic = wr_pend_q && addr_q == ivr_pkg::GIC_OFFSET;
   assign wr_fuse = wr_pend_q && addr_q == ivr_pkg::FUSE_OFFSET;

   // Read data registered from the address phase; unmapped reads zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (i_hsel && i_hready && !i_hwrite && i_htrans[1]) begin
         case (i_haddr)
            ivr_pkg::GIC_OFFSET:
               rdata_d = {30'h0000_0000, sel_d, st_d == ST_ARMED};
            ivr_pkg::FUSE_OFFSET: rdata_d = {24'h00_0000, fuse_d};
            ivr_pkg::STAT_OFFSET:
               rdata_d = {18'h0_0000, blk_d, irq_d, vec_d};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Unlock window, select bit and fuse shadow
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      sel_d = sel_q;
      fuse_d = fuse_q;
      if (wr_fuse) begin
         fuse_d = i_hwdata[7:0];
      end
      case (st_q)
         ST_IDLE: begin
            // Select write without unlock is dropped
            if (wr_gic && i_hwdata[ivr_pkg::UNLOCK_BIT]) begin
               st_d = ST_ARMED;
               // Full count: armed for four cycles after the data-phase edge
               cnt_d = ivr_pkg::UNLOCK_CYCLES;
            end
         end
         ST_ARMED: begin
            if (wr_gic && !i_hwdata[ivr_pkg::UNLOCK_BIT]) begin
               sel_d = i_hwdata[ivr_pkg::SELECT_BIT];
               st_d = ST_TAIL;
            end else if (cnt_q == 3'h1) begin
               st_d = ST_IDLE;
            end else begin
               cnt_d = cnt_q - 3'h1;
            end
         end
         ST_TAIL: begin
            // Hold blocking until the following instruction retires
            if (i_instr_done) begin
               st_d = ST_IDLE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt gating; global enable is only read, never written
   assign seq_block = st_q != ST_IDLE;
   assign in_boot = i_core_pc >= boot_start;
   assign lock_block = (sel_q && !fuse_q[ivr_pkg::APP_LOCK_BIT] && !in_boot) ||
      (!sel_q && !fuse_q[ivr_pkg::BOOT_LOCK_BIT] && in_boot);

   // Lowest numbered source wins
   always_comb begin
      vec_num = 5'h00;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (i_irq_src[i]) begin
            vec_num = 5'(i + 1);
         end
      end
   end

   ivr_vector_calc u_calc (
      .i_boot_size(fuse_q[ivr_pkg::BOOT_SIZE_LO +: 2]),
      .i_boot_reset_n(fuse_q[ivr_pkg::BOOT_RESET_BIT]),
      .i_select(sel_q),
      .i_vec_num(vec_num),
      .o_boot_start(boot_start),
      .o_reset_addr(reset_addr),
      .o_vec_addr(vec_addr)
   );

   // Registered core outputs
   always_comb begin
      blk_d = seq_block || lock_block;
      irq_d = (|i_irq_src) && i_global_ie && !blk_d;
      vec_d = vec_addr;
      rst_d = reset_addr;
   end

   ////////////////////////////////////////////////////////////////////////
   // All state registers
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         st_q <= ST_IDLE;
         cnt_q <= 3'h0;
         sel_q <= ivr_pkg::GIC_RESET[ivr_pkg::SELECT_BIT];
         fuse_q <= ivr_pkg::FUSE_RESET;
         wr_pend_q <= 1'b0;
         addr_q <= 8'h00;
         rdata_q <= 32'h0000_0000;
         irq_q <= 1'b0;
         vec_q <= 12'h000;
         rst_q <= 12'h000;
         blk_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         sel_q <= sel_d;
         fuse_q <= fuse_d;
         wr_pend_q <= wr_pend_d;
         addr_q <= addr_d;
         rdata_q <= rdata_d;
         irq_q <= irq_d;
         vec_q <= vec_d;
         rst_q <= rst_d;
         blk_q <= blk_d;
      end
   end

   assign o_hrdata = rdata_q;
   assign o_hreadyout = 1'b1;
   assign o_hresp = ivr_pkg::HRESP_OKAY;
   assign o_irq_req = irq_q;
   assign o_irq_vector = vec_q;
   assign o_reset_vector = rst_q;
   assign o_irq_blocked = blk_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence s_unlock;
      wr_gic && i_hwdata[ivr_pkg::UNLOCK_BIT] && st_q == ST_IDLE;
   endsequence

   chk_unlock_blocks: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      s_unlock |=> seq_block ##1 !irq_q)
      else $error("interrupt not blocked after unlock");

   chk_timeout_release: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      s_unlock ##1 (!wr_gic) [*4] |=> st_q == ST_IDLE)
      else $error("unlock window not closed after four cycles");

   chk_unlock_window: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      s_unlock |=> ##[0:4] st_q != ST_ARMED)
      else $error("unlock bit held too long");

   // Window must not close early, or a timely select write is lost
   sequence s_no_gic_write3;
      (!wr_gic) [*3];
   endsequence

   chk_window_length: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      s_unlock ##1 s_no_gic_write3 |=> st_q == ST_ARMED)
      else $error("unlock window closed early");

   // Tail waits for exactly one retired instruction
   chk_tail_hold: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      st_q == ST_TAIL && !i_instr_done |=> st_q == ST_TAIL)
      else $error("tail left before instruction retired");

   chk_tail_release: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      st_q == ST_TAIL && i_instr_done |=> st_q == ST_IDLE)
      else $error("tail kept after instruction retired");

   // Any active sequence state shows as blocked one cycle later
   chk_seq_blocked: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      st_q != ST_IDLE |=> o_irq_blocked)
      else $error("sequence active but not blocked");

   // Request follows pending, enable and blocking; the enable is only read
   chk_request_gate: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      1'b1 |=> o_irq_req == ($past(i_irq_src) != '0 && $past(i_global_ie) && !o_irq_blocked))
      else $error("request not gated by pending, enable and block");

   // A second unlock write while armed must not touch the select bit
   chk_rearm_ignored: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      st_q == ST_ARMED && wr_gic && i_hwdata[ivr_pkg::UNLOCK_BIT] |=> sel_q == $past(sel_q))
      else $error("select changed by unlock write");

   // Unprogrammed boot reset fuse keeps the reset vector at zero
   chk_reset_zero: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      fuse_q[ivr_pkg::BOOT_RESET_BIT] ##1 $stable(fuse_q) |-> o_reset_vector == 12'h000)
      else $error("reset vector not zero with fuse unprogrammed");

   // Fixed table corners, independent of the adder above
   chk_table_bottom: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      !sel_q && vec_num == 5'h01 |=> o_irq_vector == 12'h001)
      else $error("first vector not at word one");

   chk_boot_first: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      sel_q && fuse_q[ivr_pkg::BOOT_SIZE_LO +: 2] == 2'h0 && vec_num == 5'h01
      |=> o_irq_vector == 12'hC01)
      else $error("first relocated vector wrong");

   chk_boot_last: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      sel_q && fuse_q[ivr_pkg::BOOT_SIZE_LO +: 2] == 2'h0 && vec_num == 5'h12
      |=> o_irq_vector == 12'hC12)
      else $error("last relocated vector wrong");

   chk_locked_select: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      st_q != ST_ARMED |=> sel_q == $past(sel_q))
      else $error("select changed without unlock");

   chk_select_write: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      st_q == ST_ARMED && wr_gic && !i_hwdata[ivr_pkg::UNLOCK_BIT]
      |=> sel_q == $past(i_hwdata[ivr_pkg::SELECT_BIT]) && st_q == ST_TAIL)
      else $error("select write not taken");

   chk_app_lock: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      sel_q && !fuse_q[ivr_pkg::APP_LOCK_BIT] && i_core_pc < boot_start |=> !irq_q)
      else $error("interrupt in application with app lock");

   chk_boot_lock: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      !sel_q && !fuse_q[ivr_pkg::BOOT_LOCK_BIT] && i_core_pc >= boot_start |=> !irq_q)
      else $error("interrupt in boot area with boot lock");

   chk_vector_base: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      1'b1 |=> vec_q == ($past(sel_q) ? $past(boot_start) : 12'h000) + $past({7'h00, vec_num}))
      else $error("vector address wrong");

   chk_reset_addr: assert property (@(posedge i_sys_clk) disable iff (i_sys_rst)
      !fuse_q[ivr_pkg::BOOT_RESET_BIT] ##1 $stable(fuse_q) |-> rst_q == $past(boot_start))
      else $error("reset vector not at boot start");
endmodule

// ### sim/ivr_core_model.sv
// Processor core model: program counter, sources, enable bit and retire pulses
`timescale 1ns/100ps
module ivr_core_model (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic [11:0] i_pc,
   input wire logic [17:0] i_src,
   input wire logic i_ie,
   output logic [11:0] o_pc,
   output logic [17:0] o_src,
   output logic o_ie,
   output logic o_done
);
   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   // Retire every third cycle, so the post-select tail lasts a while
   always_comb begin
      cnt_d = (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
   end
   always_ff @(posedge i_sys_clk) begin
      cnt_q <= i_sys_rst ? 2'h0 : cnt_d;
   end
   assign o_done = (cnt_q == 2'h2);
   // Status enable bit belongs to the core alone
   assign o_ie = i_ie;
   assign o_pc = i_pc;
   assign o_src = i_src;
endmodule

// ### sim/tb_top.sv
// Self-checking bench for the vector relocation block
`timescale 1ns/100ps
module tb_top;
   logic clk, rst, hsel, hwrite, hrdy, hresp, ie, cie, done, req, blk;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd, seed;
   logic [11:0] pc, cpc, vec, rvec;
   logic [17:0] src, csrc;
   int bad_count, checks;
   ivr_core_model core (.i_sys_clk(clk), .i_sys_rst(rst), .i_pc(pc), .i_src(src), .i_ie(ie),
      .o_pc(cpc), .o_src(csrc), .o_ie(cie), .o_done(done));
   ivr_top dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
      .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
      .i_core_pc(cpc), .i_instr_done(done), .i_irq_src(csrc), .i_global_ie(cie),
      .o_irq_req(req), .o_irq_vector(vec), .o_reset_vector(rvec), .o_irq_blocked(blk));
   ////////////////////////////////////////////////////////////////////////////
   // Clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [11:0] bstart(input logic [1:0] c);
      return c == 2'h0 ? ivr_pkg::BOOT_START_0 : c == 2'h1 ? ivr_pkg::BOOT_START_1 :
         c == 2'h2 ? ivr_pkg::BOOT_START_2 : ivr_pkg::BOOT_START_3;
   endfunction
   // Lowest set source wins, one word per entry after the table base
   function automatic logic [11:0] vexp(input logic sel, input logic [1:0] c,
      input logic [17:0] s);
      int k;
      k = 0;
      for (int j = 17; j >= 0; j--) if (s[j]) k = j;
      return (sel ? bstart(c) : 12'h000) + 12'h001 + 12'(k);
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", n, e, g);
         bad_count++;
      end
   endtask
   // Single AHB transfer; hold each phase until hready is sampled high
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      haddr <= a;
      hwrite <= w;
      htrans <= ivr_pkg::HTRANS_NONSEQ;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      rd = hrdata;
   endtask
   task automatic rdchk(input string n, input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(n, e, rd);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Random pending sets; first pass is the last source as a corner
   task automatic rnd_irq(input logic sel, input logic [1:0] c, input int n);
      logic [17:0] s;
      for (int i = 0; i < n; i++) begin
         seed = lfsr(seed);
         s = seed[17:0] >> seed[21:18];
         if (i == 0 || s == 18'h0) s = 18'h20000;
         src <= s;
         tick(3);
         chk("irq_req", 32'h1, 32'(req));
         chk("irq_vector", 32'(vexp(sel, c, s)), 32'(vec));
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Watchdog far beyond the few hundred cycles of the sequence
   initial begin
      tick(20000);
      bad_count++;
      test_done;
   end
   // Main sequence
   initial begin
      {rst, hsel, hsize, seed} = {1'b1, 1'b1, 3'h2, 32'h6e7f};
      {haddr, htrans, hwrite, hwdata, pc, src, ie} = '0;
      tick(6);
      rst <= 1'b0;
      ie <= 1'b1;
      tick(2);
      chk("reset_vector", 32'h0, 32'(rvec));
      rdchk("control", ivr_pkg::GIC_OFFSET, 32'h0);
      rdchk("fuses", ivr_pkg::FUSE_OFFSET, 32'h19);
      rnd_irq(1'b0, 2'h0, 12);
      ie <= 1'b0;
      tick(3);
      chk("irq_req", 32'h0, 32'(req));
      ie <= 1'b1;
      bus(1'b1, ivr_pkg::GIC_OFFSET, 32'h2);
      rdchk("control", ivr_pkg::GIC_OFFSET, 32'h0);
      bus(1'b1, ivr_pkg::GIC_OFFSET, 32'h1);
      rdchk("control", ivr_pkg::GIC_OFFSET, 32'h1);
      chk("blocked", 32'h1, 32'(blk));
      tick(8);
      chk("blocked", 32'h0, 32'(blk));
      rdchk("control", ivr_pkg::GIC_OFFSET, 32'h0);
      bus(1'b1, ivr_pkg::GIC_OFFSET, 32'h1);
      bus(1'b1, ivr_pkg::GIC_OFFSET, 32'h2);
      chk("blocked", 32'h1, 32'(blk));
      chk("irq_req", 32'h0, 32'(req));
      tick(10);
      chk("blocked", 32'h0, 32'(blk));
      rdchk("control", ivr_pkg::GIC_OFFSET, 32'h2);
      rnd_irq(1'b1, 2'h0, 8);
      // Boot reset programmed, every boot size code
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, ivr_pkg::FUSE_OFFSET, 32'h18 | (c << 1));
         tick(2);
         chk("reset_vector", 32'(bstart(2'(c))), 32'(rvec));
         rnd_irq(1'b1, 2'(c), 5);
      end
      // Lock bits against the executing area
      bus(1'b1, ivr_pkg::FUSE_OFFSET, 32'h10);
      pc <= 12'h100;
      src <= 18'h1;
      tick(3);
      chk("irq_req", 32'h0, 32'(req));
      pc <= 12'hC50;
      tick(3);
      chk("irq_req", 32'h1, 32'(req));
      bus(1'b1, ivr_pkg::GIC_OFFSET, 32'h1);
      bus(1'b1, ivr_pkg::GIC_OFFSET, 32'h0);
      bus(1'b1, ivr_pkg::FUSE_OFFSET, 32'h08);
      tick(10);
      chk("irq_req", 32'h0, 32'(req));
      pc <= 12'h100;
      tick(3);
      chk("irq_req", 32'h1, 32'(req));
      chk("irq_vector", 32'h1, 32'(vec));
      // Status word: blocked clear, request set, vector word one
      rdchk("status", ivr_pkg::STAT_OFFSET, 32'h0000_1001);
      test_done;
   end
endmodule
